// ===== include/fault_ctrl_pkg.sv
// Constants shared by the fault flag and output control block.
// Assumes command codes arrive already decoded by the bus engine.
package fault_ctrl_pkg;

   localparam int FLAG_W = 8;

   // Command codes that select a register
   localparam logic [7:0] CMD_LIVE    = 8'hD0;
   localparam logic [7:0] CMD_FAULT   = 8'hD1;
   localparam logic [7:0] CMD_ALERT   = 8'hD2;
   localparam logic [7:0] CMD_CONTROL = 8'hD4;

   // Flag positions, identical in live, fault and mask registers
   localparam int POS_OVERVOLT  = 0;
   localparam int POS_UNDERVOLT = 1;
   localparam int POS_OVERCUR   = 2;
   localparam int POS_FEED_B    = 3;
   localparam int POS_FEED_A    = 4;
   localparam int POS_ORING     = 5;
   localparam int POS_OVERTEMP  = 6;
   localparam int POS_HOLDUP    = 7;

   // Control register fields
   localparam int POS_OUT1_OFF     = 5;
   localparam int POS_OUT1_RESTART = 6;

   // Reset values
   localparam logic [7:0] FAULT_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic       OFF_RESET   = 1'b0;

   // Forced restart off interval
   localparam int SYS_CLK_MHZ    = 250;
   localparam int RESTART_OFF_US = 1000;
   localparam int RESTART_CYCLES = RESTART_OFF_US * SYS_CLK_MHZ;

   localparam int SYNC_STAGES = 2;

endpackage

// ===== hw/level_sync.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words must not use it.
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_en,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } state_type;

   state_type s_q;
   state_type s_d;

   always_comb begin
      s_d    = s_q;
      s_d.s1 = i_d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else if (i_en) begin
         s_q <= s_d;
      end
   end

   assign o_q = s_q.s2;

endmodule

// ===== hw/link_handshake.sv
// Carries one register request from the link clock to the system clock
// and its read data back, by toggle request and toggle acknowledge.
// Assumes the link clock runs until o_done has been seen.
`timescale 1ns/1ps
module link_handshake (
   input  wire logic       i_link_clk,
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_en,
   input  wire logic       i_req,
   input  wire logic       i_write,
   input  wire logic [7:0] i_cmd,
   input  wire logic [7:0] i_wdata,
   output logic            o_busy,
   output logic            o_done,
   output logic      [7:0] o_rdata,
   output logic            o_sys_req,
   output logic            o_sys_write,
   output logic      [7:0] o_sys_cmd,
   output logic      [7:0] o_sys_wdata,
   input  wire logic [7:0] i_sys_rdata
);

   typedef struct packed {
      logic       req_tgl;
      logic       busy;
      logic       write;
      logic [7:0] cmd;
      logic [7:0] wdata;
      logic       ack_s1;
      logic       ack_s2;
      logic       ack_seen;
      logic [7:0] rdata;
      logic       done;
   } link_state_type;

   typedef struct packed {
      logic       req_s1;
      logic       req_s2;
      logic       req_seen;
      logic       ack_tgl;
      logic [7:0] rdata;
   } sys_state_type;

   link_state_type l_q;
   link_state_type l_d;
   sys_state_type  y_q;
   sys_state_type  y_d;
   logic           sys_new;

   // Command fields stay still while busy, so the system side samples them safely
   always_comb begin
      l_d        = l_q;
      l_d.done   = 1'b0;
      l_d.ack_s1 = y_q.ack_tgl;
      l_d.ack_s2 = l_q.ack_s1;
      if (l_q.ack_s2 != l_q.ack_seen) begin
         l_d.ack_seen = l_q.ack_s2;
         l_d.busy     = 1'b0;
         l_d.rdata    = y_q.rdata;
         l_d.done     = 1'b1;
      // A request still held in the done cycle belongs to the finished transfer
      end else if (i_req && !l_q.busy && !l_q.done) begin
         l_d.req_tgl = ~l_q.req_tgl;
         l_d.busy    = 1'b1;
         l_d.write   = i_write;
         l_d.cmd     = i_cmd;
         l_d.wdata   = i_wdata;
      end
   end

   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   assign sys_new = (y_q.req_s2 != y_q.req_seen);

   always_comb begin
      y_d        = y_q;
      y_d.req_s1 = l_q.req_tgl;
      y_d.req_s2 = y_q.req_s1;
      if (sys_new) begin
         y_d.req_seen = y_q.req_s2;
         y_d.ack_tgl  = ~y_q.ack_tgl;
         y_d.rdata    = i_sys_rdata;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         y_q <= '0;
      end else if (i_en) begin
         y_q <= y_d;
      end
   end

   assign o_busy      = l_q.busy;
   assign o_done      = l_q.done;
   assign o_rdata     = l_q.rdata;
   assign o_sys_req   = sys_new & i_en;
   assign o_sys_write = l_q.write;
   assign o_sys_cmd   = l_q.cmd;
   assign o_sys_wdata = l_q.wdata;

endmodule

// ===== hw/fault_flag_and_output_control.sv
// Live condition flags, latched fault flags, alert masking and the
// output 1 control register of a dual-feed input power module.
// Assumes condition inputs are comparator levels from the analog side
// and register requests come from a bus engine on the link clock.
//
// Summary of operation
// - Over-voltage flag live; turns output 1 off
// - Under-voltage flag live; lockout turns output off
// - Over-current flag on over-current or over-power
// - Feed low on alarm-on or below alarm-off
// - ORing short flag needs current above minimum
// - Over-temperature warning flag at lower threshold
// - Higher temperature threshold turns output 1 off
// - Hold-up flag when output reaches threshold
// - Control register readable and writable by host
// - Control bit 5 set turns output off
// - Bit 6 forces timed off then restart
// - Restart bit self-clears when the off interval ends
// - Restart bit one requests, zero is idle
// - Live flags follow conditions; fault flags latch
// - Fault flag cleared only by writing one
// - Alert raised by a newly latched enabled fault, held until a mask write or no enabled fault set
// - A mask register write drops the alert unless a new enabled fault latches in the same cycle
`timescale 1ns/1ps
module fault_flag_and_output_control #(
   parameter int RESTART_CYCLES = fault_ctrl_pkg::RESTART_CYCLES
) (
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RESET,
   input  wire logic       I_CLK_EN,
   input  wire logic       I_LINK_CLK,
   input  wire logic       I_LINK_REQ,
   input  wire logic       I_LINK_WRITE,
   input  wire logic [7:0] I_LINK_CMD,
   input  wire logic [7:0] I_LINK_WDATA,
   output logic            O_LINK_BUSY,
   output logic            O_LINK_DONE,
   output logic      [7:0] O_LINK_RDATA,
   input  wire logic       I_COND_OVERVOLT,
   input  wire logic       I_COND_UNDERVOLT,
   input  wire logic       I_COND_OVERCURRENT,
   input  wire logic       I_COND_OVERPOWER,
   input  wire logic       I_FEED_A_ALARM_ON,
   input  wire logic       I_FEED_A_BELOW_OFF,
   input  wire logic       I_FEED_B_ALARM_ON,
   input  wire logic       I_FEED_B_BELOW_OFF,
   input  wire logic       I_ORING_SHORT,
   input  wire logic       I_ORING_ABOVE_MIN,
   input  wire logic       I_TEMP_WARN,
   input  wire logic       I_TEMP_TRIP,
   input  wire logic       I_HOLDUP_REACHED,
   input  wire logic       I_ALERT_IN,
   output logic            O_ALERT_OUT,
   output logic            O_ALERT_OE,
   output logic            O_OUT1_ENABLE
);

   localparam int COND_W = 13;
   localparam int CNT_W  = $clog2(RESTART_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RESTART_CYCLES - 1);

   // Condition vector positions after synchronising
   localparam int C_OV   = 0;
   localparam int C_UV   = 1;
   localparam int C_OC   = 2;
   localparam int C_OP   = 3;
   localparam int C_FAON = 4;
   localparam int C_FAOF = 5;
   localparam int C_FBON = 6;
   localparam int C_FBOF = 7;
   localparam int C_FET  = 8;
   localparam int C_IMIN = 9;
   localparam int C_TW   = 10;
   localparam int C_TT   = 11;
   localparam int C_HU   = 12;

   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,
      RS_HOLD = 2'b10
   } restart_state_type;

   typedef struct packed {
      logic [7:0]        live;
      logic [7:0]        fault;
      logic [7:0]        mask;
      logic              trip;
      logic              off;
      logic              restart;
      restart_state_type rst_st;
      logic [CNT_W-1:0]  cnt;
      logic              alert;
      logic              out1_en;
   } state_type;

   localparam state_type S_RESET = '{
      live:    8'h00,
      fault:   fault_ctrl_pkg::FAULT_RESET,
      mask:    fault_ctrl_pkg::MASK_RESET,
      trip:    1'b0,
      off:     fault_ctrl_pkg::OFF_RESET,
      restart: 1'b0,
      rst_st:  RS_IDLE,
      cnt:     '0,
      alert:   1'b0,
      out1_en: 1'b0
   };

   state_type         s_q;
   state_type         s_d;
   logic [COND_W-1:0] cond_raw;
   logic [COND_W-1:0] cond;
   logic              sys_req;
   logic              sys_write;
   logic [7:0]        sys_cmd;
   logic [7:0]        sys_wdata;
   logic [7:0]        sys_rdata;
   logic              wr_fault;
   logic              wr_mask;
   logic              wr_ctrl;
   logic [7:0]        live_n;
   logic [7:0]        fault_clr;
   logic [7:0]        enabled_n;
   logic              new_event;
   logic [7:0]        ctrl_rd;

   assign cond_raw[C_OV]   = I_COND_OVERVOLT;
   assign cond_raw[C_UV]   = I_COND_UNDERVOLT;
   assign cond_raw[C_OC]   = I_COND_OVERCURRENT;
   assign cond_raw[C_OP]   = I_COND_OVERPOWER;
   assign cond_raw[C_FAON] = I_FEED_A_ALARM_ON;
   assign cond_raw[C_FAOF] = I_FEED_A_BELOW_OFF;
   assign cond_raw[C_FBON] = I_FEED_B_ALARM_ON;
   assign cond_raw[C_FBOF] = I_FEED_B_BELOW_OFF;
   assign cond_raw[C_FET]  = I_ORING_SHORT;
   assign cond_raw[C_IMIN] = I_ORING_ABOVE_MIN;
   assign cond_raw[C_TW]   = I_TEMP_WARN;
   assign cond_raw[C_TT]   = I_TEMP_TRIP;
   assign cond_raw[C_HU]   = I_HOLDUP_REACHED;

   // Comparator levels are asynchronous to the system clock
   level_sync #(
      .WIDTH (COND_W)
   ) u_cond_sync (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RESET),
      .i_en  (I_CLK_EN),
      .i_d   (cond_raw),
      .o_q   (cond)
   );

   link_handshake u_link (
      .i_link_clk  (I_LINK_CLK),
      .i_sys_clk   (I_CLK_SYS),
      .i_rst       (I_RESET),
      .i_en        (I_CLK_EN),
      .i_req       (I_LINK_REQ),
      .i_write     (I_LINK_WRITE),
      .i_cmd       (I_LINK_CMD),
      .i_wdata     (I_LINK_WDATA),
      .o_busy      (O_LINK_BUSY),
      .o_done      (O_LINK_DONE),
      .o_rdata     (O_LINK_RDATA),
      .o_sys_req   (sys_req),
      .o_sys_write (sys_write),
      .o_sys_cmd   (sys_cmd),
      .o_sys_wdata (sys_wdata),
      .i_sys_rdata (sys_rdata)
   );

   assign wr_fault = sys_req & sys_write & (sys_cmd == fault_ctrl_pkg::CMD_FAULT);
   assign wr_mask  = sys_req & sys_write & (sys_cmd == fault_ctrl_pkg::CMD_ALERT);
   assign wr_ctrl  = sys_req & sys_write & (sys_cmd == fault_ctrl_pkg::CMD_CONTROL);

   // Live flags follow the synchronised conditions
   always_comb begin
      live_n                                = 8'h00;
      live_n[fault_ctrl_pkg::POS_OVERVOLT]  = cond[C_OV];
      live_n[fault_ctrl_pkg::POS_UNDERVOLT] = cond[C_UV];
      live_n[fault_ctrl_pkg::POS_OVERCUR]   = cond[C_OC] | cond[C_OP];
      live_n[fault_ctrl_pkg::POS_FEED_B]    = cond[C_FBON] | cond[C_FBOF];
      live_n[fault_ctrl_pkg::POS_FEED_A]    = cond[C_FAON] | cond[C_FAOF];
      live_n[fault_ctrl_pkg::POS_ORING]     = cond[C_FET] & cond[C_IMIN];
      live_n[fault_ctrl_pkg::POS_OVERTEMP]  = cond[C_TW];
      live_n[fault_ctrl_pkg::POS_HOLDUP]    = cond[C_HU];
   end

   assign fault_clr = wr_fault ? sys_wdata : 8'h00;

   always_comb begin
      s_d      = s_q;
      s_d.live = live_n;
      s_d.trip = cond[C_TT];

      // A flag raised in the same cycle as its clear stays set
      s_d.fault = (s_q.fault & ~fault_clr) | s_q.live;

      if (wr_mask) begin
         s_d.mask = sys_wdata;
      end

      if (wr_ctrl) begin
         s_d.off = sys_wdata[fault_ctrl_pkg::POS_OUT1_OFF];
      end

      // Writing zero to the restart bit never aborts a running restart
      unique case (s_q.rst_st)
         RS_IDLE: begin
            if (wr_ctrl && sys_wdata[fault_ctrl_pkg::POS_OUT1_RESTART]) begin
               s_d.restart = 1'b1;
               s_d.rst_st  = RS_HOLD;
               s_d.cnt     = CNT_LOAD;
            end
         end
         RS_HOLD: begin
            if (s_q.cnt == '0) begin
               s_d.restart = 1'b0;
               s_d.rst_st  = RS_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         default: begin
            s_d.restart = 1'b0;
            s_d.rst_st  = RS_IDLE;
            s_d.cnt     = '0;
         end
      endcase

      // Only a newly latched enabled fault raises the alert, so a mask
      // write can silence flags that are already standing
      if (new_event) begin
         s_d.alert = 1'b1;
      end else if (wr_mask || enabled_n == 8'h00) begin
         s_d.alert = 1'b0;
      end

      s_d.out1_en = ~s_d.off
                    & (s_d.rst_st == RS_IDLE)
                    & ~s_d.live[fault_ctrl_pkg::POS_OVERVOLT]
                    & ~s_d.live[fault_ctrl_pkg::POS_UNDERVOLT]
                    & ~s_d.trip;
   end

   assign enabled_n = ((s_q.fault & ~fault_clr) | s_q.live) & (wr_mask ? sys_wdata : s_q.mask);
   assign new_event = |(enabled_n & ~s_q.fault);

   // Reserved control bits read as zero
   always_comb begin
      ctrl_rd                                   = 8'h00;
      ctrl_rd[fault_ctrl_pkg::POS_OUT1_OFF]     = s_q.off;
      ctrl_rd[fault_ctrl_pkg::POS_OUT1_RESTART] = s_q.restart;
   end

   // Unmapped command codes read as zero and ignore writes
   always_comb begin
      unique case (sys_cmd)
         fault_ctrl_pkg::CMD_LIVE:    sys_rdata = s_q.live;
         fault_ctrl_pkg::CMD_FAULT:   sys_rdata = s_q.fault;
         fault_ctrl_pkg::CMD_ALERT:   sys_rdata = s_q.mask;
         fault_ctrl_pkg::CMD_CONTROL: sys_rdata = ctrl_rd;
         default:                     sys_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         s_q <= S_RESET;
      end else if (I_CLK_EN) begin
         s_q <= s_d;
      end
   end

   // Open-drain alert: pulls low only while the alert stands
   assign O_ALERT_OUT   = 1'b0;
   assign O_ALERT_OE    = s_q.alert;
   assign O_OUT1_ENABLE = s_q.out1_en;

endmodule

// ===== test/fault_ctrl_properties.sv
// Concurrent checks on the fault flag and output control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module fault_ctrl_properties #(
   parameter int RESTART_CYCLES = 20
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_LINK_CLK,
   input wire logic I_LINK_REQ,
   input wire logic O_LINK_BUSY,
   input wire logic O_LINK_DONE,
   input wire logic I_COND_OVERVOLT,
   input wire logic I_COND_UNDERVOLT,
   input wire logic I_COND_OVERCURRENT,
   input wire logic I_COND_OVERPOWER,
   input wire logic I_FEED_A_ALARM_ON,
   input wire logic I_FEED_A_BELOW_OFF,
   input wire logic I_FEED_B_ALARM_ON,
   input wire logic I_FEED_B_BELOW_OFF,
   input wire logic I_ORING_SHORT,
   input wire logic I_TEMP_WARN,
   input wire logic I_TEMP_TRIP,
   input wire logic I_HOLDUP_REACHED,
   input wire logic O_ALERT_OUT,
   input wire logic O_ALERT_OE,
   input wire logic O_OUT1_ENABLE
);
   logic       any_cond;
   logic [3:0] since_q;
   assign any_cond = |{I_COND_OVERVOLT, I_COND_UNDERVOLT, I_COND_OVERCURRENT, I_COND_OVERPOWER,
                       I_FEED_A_ALARM_ON, I_FEED_A_BELOW_OFF, I_FEED_B_ALARM_ON, I_FEED_B_BELOW_OFF,
                       I_ORING_SHORT, I_TEMP_WARN, I_HOLDUP_REACHED};
   // Cycles since the last condition; saturates so an old condition never looks recent to the alert check
   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) since_q <= 4'hF;
      else if (any_cond) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
   end
   sequence s_taken;
      I_LINK_REQ && !O_LINK_BUSY && !O_LINK_DONE;
   endsequence
   sequence s_answer;
      O_LINK_BUSY ##[1:8] O_LINK_DONE;
   endsequence
   a_ov_out_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_COND_OVERVOLT [*6] |-> !O_OUT1_ENABLE) else $error("output on during over-voltage");
   a_uv_out_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_COND_UNDERVOLT [*6] |-> !O_OUT1_ENABLE) else $error("output on during under-voltage");
   a_trip_out_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      I_TEMP_TRIP [*6] |-> !O_OUT1_ENABLE) else $error("output on during over-temperature");
   a_alert_has_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      $rose(O_ALERT_OE) |-> since_q <= 4'h8) else $error("alert raised without a new fault");
   a_alert_pulls_low: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
      O_ALERT_OE |-> !O_ALERT_OUT) else $error("alert pin driven high");
   a_req_sets_busy: assert property (@(posedge I_LINK_CLK) disable iff (I_RESET)
      s_taken |=> O_LINK_BUSY) else $error("request not taken");
   a_req_answered: assert property (@(posedge I_LINK_CLK) disable iff (I_RESET)
      s_taken |=> s_answer) else $error("request not answered");
   a_done_one_cycle: assert property (@(posedge I_LINK_CLK) disable iff (I_RESET)
      O_LINK_DONE |=> !O_LINK_DONE) else $error("done longer than one cycle");
endmodule

// ===== test/host_link_model.sv
// Host side of the register link: one byte request at a time.
// Assumes a free running link clock and a done pulse per request.
`timescale 1ns/1ps
module host_link_model (
   input  wire logic       i_link_clk,
   input  wire logic       i_busy,
   input  wire logic       i_done,
   input  wire logic [7:0] i_rdata,
   output logic            o_req,
   output logic            o_write,
   output logic      [7:0] o_cmd,
   output logic      [7:0] o_wdata
);
   initial begin
      o_req = 1'b0;
      o_write = 1'b0;
      o_cmd = 8'hA5;
      o_wdata = 8'h5A;
   end
   // Request held until done is sampled or 20 link cycles pass; released lines show inverted values
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ok);
      int n;
      @(posedge i_link_clk);
      o_req <= 1'b1;
      o_write <= wr;
      o_cmd <= cmd;
      o_wdata <= wd;
      n = 0;
      do begin
         @(posedge i_link_clk);
         n++;
      end while (!i_done && n < 20);
      ok = i_done;
      rd = i_rdata;
      o_req <= 1'b0;
      o_write <= ~wr;
      o_cmd <= ~cmd;
      o_wdata <= ~wd;
   endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the fault flag and output control block.
// Assumes the host model drives the register link on its own clock.
`timescale 1ns/1ps
module tb;
   localparam int RP = 200;
   logic        clk, lclk, rst, ok;
   logic        busy, done, req, wr, out1, aoe, aout;
   logic [12:0] c;
   logic [7:0]  rdata, cmd, wd, rd;
   int          n_errors, n_checks, cyc, run, off_len;
   logic [12:0] tc [13] = '{13'h0001, 13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020, 13'h0040,
                            13'h0080, 13'h0300, 13'h0100, 13'h0400, 13'h0800, 13'h1000};
   logic [7:0]  tf [13] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h10, 8'h10, 8'h08, 8'h08, 8'h20, 8'h00,
                            8'h40, 8'h00, 8'h80};
   logic [12:0] toff = 13'h0803;
   fault_flag_and_output_control #(.RESTART_CYCLES(RP)) dut (
      .I_CLK_SYS(clk), .I_RESET(rst), .I_CLK_EN(1'b1), .I_LINK_CLK(lclk),
      .I_LINK_REQ(req), .I_LINK_WRITE(wr), .I_LINK_CMD(cmd), .I_LINK_WDATA(wd),
      .O_LINK_BUSY(busy), .O_LINK_DONE(done), .O_LINK_RDATA(rdata),
      .I_COND_OVERVOLT(c[0]), .I_COND_UNDERVOLT(c[1]), .I_COND_OVERCURRENT(c[2]),
      .I_COND_OVERPOWER(c[3]), .I_FEED_A_ALARM_ON(c[4]), .I_FEED_A_BELOW_OFF(c[5]),
      .I_FEED_B_ALARM_ON(c[6]), .I_FEED_B_BELOW_OFF(c[7]), .I_ORING_SHORT(c[8]),
      .I_ORING_ABOVE_MIN(c[9]), .I_TEMP_WARN(c[10]), .I_TEMP_TRIP(c[11]),
      .I_HOLDUP_REACHED(c[12]), .I_ALERT_IN(1'b1),
      .O_ALERT_OUT(aout), .O_ALERT_OE(aoe), .O_OUT1_ENABLE(out1));
   host_link_model host (.i_link_clk(lclk), .i_busy(busy), .i_done(done), .i_rdata(rdata),
      .o_req(req), .o_write(wr), .o_cmd(cmd), .o_wdata(wd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #32 lclk = ~lclk;
   end
   always @(posedge clk) begin
      cyc++;
      if (!out1) run++;
      else begin
         if (run != 0) off_len = run;
         run = 0;
      end
      if (cyc == 60000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(1'b0, a, 8'h00, rd, ok);
      chk({7'h00, ok}, 8'h01);
      chk(rd, exp);
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, rd, ok);
      chk({7'h00, ok}, 8'h01);
   endtask
   task automatic setc(input logic [12:0] v);
      @(posedge clk);
      c <= v;
      repeat (10) @(posedge clk);
   endtask
   task automatic t_reset;
      rdc(fault_ctrl_pkg::CMD_LIVE, 8'h00);
      rdc(fault_ctrl_pkg::CMD_FAULT, 8'h00);
      rdc(fault_ctrl_pkg::CMD_ALERT, 8'h00);
      rdc(fault_ctrl_pkg::CMD_CONTROL, 8'h00);
      rdc(8'h55, 8'h00);
      chk({6'h00, out1, aoe}, 8'h02);
      $display("test reset done");
   endtask
   task automatic t_flags;
      for (int i = 0; i < 13; i++) begin
         setc(tc[i]);
         chk({7'h00, out1}, {7'h00, ~toff[i]});
         rdc(fault_ctrl_pkg::CMD_LIVE, tf[i]);
         setc(13'h0000);
         chk({7'h00, out1}, 8'h01);
         rdc(fault_ctrl_pkg::CMD_LIVE, 8'h00);
         rdc(fault_ctrl_pkg::CMD_FAULT, tf[i]);
         wrt(fault_ctrl_pkg::CMD_FAULT, 8'h00);
         rdc(fault_ctrl_pkg::CMD_FAULT, tf[i]);
         wrt(fault_ctrl_pkg::CMD_FAULT, 8'hFF);
         rdc(fault_ctrl_pkg::CMD_FAULT, 8'h00);
      end
      $display("test flags done");
   endtask
   task automatic t_alert;
      wrt(fault_ctrl_pkg::CMD_ALERT, 8'h01);
      setc(13'h0001);
      setc(13'h0000);
      chk({7'h00, aoe}, 8'h01);
      wrt(fault_ctrl_pkg::CMD_FAULT, 8'h00);
      chk({7'h00, aoe}, 8'h01);
      wrt(fault_ctrl_pkg::CMD_FAULT, 8'h01);
      chk({7'h00, aoe}, 8'h00);
      setc(13'h0001);
      setc(13'h0000);
      chk({7'h00, aoe}, 8'h01);
      wrt(fault_ctrl_pkg::CMD_ALERT, 8'h01);
      chk({7'h00, aoe}, 8'h00);
      rdc(fault_ctrl_pkg::CMD_FAULT, 8'h01);
      setc(13'h0002);
      setc(13'h0000);
      chk({7'h00, aoe}, 8'h00);
      wrt(fault_ctrl_pkg::CMD_FAULT, 8'hFF);
      rdc(fault_ctrl_pkg::CMD_ALERT, 8'h01);
      $display("test alert done");
   endtask
   task automatic t_ctrl;
      int n;
      wrt(fault_ctrl_pkg::CMD_CONTROL, 8'h40);
      chk({7'h00, out1}, 8'h00);
      rdc(fault_ctrl_pkg::CMD_CONTROL, 8'h40);
      n = 0;
      while (!out1 && n < 2 * RP) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      chk({7'h00, out1}, 8'h01);
      chk({7'h00, off_len >= RP && off_len <= RP + 1}, 8'h01);
      rdc(fault_ctrl_pkg::CMD_CONTROL, 8'h00);
      wrt(fault_ctrl_pkg::CMD_CONTROL, 8'hFF);
      repeat (2 * RP) @(posedge clk);
      rdc(fault_ctrl_pkg::CMD_CONTROL, 8'h20);
      chk({7'h00, out1}, 8'h00);
      wrt(fault_ctrl_pkg::CMD_CONTROL, 8'h9F);
      rdc(fault_ctrl_pkg::CMD_CONTROL, 8'h00);
      chk({7'h00, out1}, 8'h01);
      $display("test control done");
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      c = 13'h0000;
      // The link side resets asynchronously, so no link edge is needed here
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reset();
      t_flags();
      t_alert();
      t_ctrl();
      stop_test();
   end
endmodule
bind fault_flag_and_output_control fault_ctrl_properties #(.RESTART_CYCLES(RESTART_CYCLES)) chk_u (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_LINK_CLK(I_LINK_CLK), .I_LINK_REQ(I_LINK_REQ),
   .O_LINK_BUSY(O_LINK_BUSY), .O_LINK_DONE(O_LINK_DONE), .I_COND_OVERVOLT(I_COND_OVERVOLT),
   .I_COND_UNDERVOLT(I_COND_UNDERVOLT), .I_COND_OVERCURRENT(I_COND_OVERCURRENT),
   .I_COND_OVERPOWER(I_COND_OVERPOWER), .I_FEED_A_ALARM_ON(I_FEED_A_ALARM_ON),
   .I_FEED_A_BELOW_OFF(I_FEED_A_BELOW_OFF), .I_FEED_B_ALARM_ON(I_FEED_B_ALARM_ON),
   .I_FEED_B_BELOW_OFF(I_FEED_B_BELOW_OFF), .I_ORING_SHORT(I_ORING_SHORT), .I_TEMP_WARN(I_TEMP_WARN),
   .I_TEMP_TRIP(I_TEMP_TRIP),
   .I_HOLDUP_REACHED(I_HOLDUP_REACHED), .O_ALERT_OUT(O_ALERT_OUT), .O_ALERT_OE(O_ALERT_OE),
   .O_OUT1_ENABLE(O_OUT1_ENABLE));
